/* File: design/ics_regs.svh */
// Command codes, mode-word bit positions and timing counts for the axis block.
`ifndef ICS_REGS_SVH
`define ICS_REGS_SVH

// Start commands; the low two bits select the speed pattern.
`define ICS_CMD_START_LOW 16'h0050
`define ICS_CMD_START_HIGH 16'h0051
`define ICS_CMD_START_RAMP1 16'h0052
`define ICS_CMD_START_RAMP2 16'h0053
// Chained start commands; the low two bits select the speed pattern.
`define ICS_CMD_NEXT_LOW 16'h0058
`define ICS_CMD_NEXT_RAMP2 16'h005b
// Stop commands.
`define ICS_CMD_STOP 16'h0049
`define ICS_CMD_DECEL_STOP 16'h004a
// Broadcast that releases every axis held at start.
`define ICS_BCAST_START 16'h2001

// Mode word bit positions.
`define ICS_MD_POS 0
`define ICS_MD_CIRC 4
`define ICS_MD_HOLD 14
`define ICS_MD_DUMMY 30

// Clocks per ramp step are (rate + 1) times this figure.
`define ICS_RAMP_UNIT 8

`endif

/* File: design/ics_pkg.sv */
// Types shared by the axis block.
package ics_pkg;
   typedef enum logic [1:0] {
      ICS_IDLE = 2'b00,
      ICS_HOLD = 2'b01,
      ICS_RUN = 2'b11,
      ICS_DECEL = 2'b10
   } ics_state_t;

   typedef enum logic [1:0] {
      ICS_LOW = 2'b00,
      ICS_HIGH = 2'b01,
      ICS_RAMP1 = 2'b10,
      ICS_RAMP2 = 2'b11
   } ics_kind_t;
endpackage

/* File: design/ics_step_gen.sv */
// Phase-accumulator step generator driven by the current speed value.
`timescale 1ns/1ps
`default_nettype none
module ics_step_gen import ics_pkg::*; #(
   parameter int SPEED_W = 17,
   parameter int PHASE_W = 24
) (
   // Clock and control
   input wire logic clock,
   input wire logic srst,
   input wire logic ce,
   input wire logic run,
   // Speed
   input wire logic [SPEED_W-1:0] speed,
   // Step event, one cycle
   output logic step
);
   logic [PHASE_W-1:0] phase;
   logic [PHASE_W:0] sum;

   generate
      if (PHASE_W <= SPEED_W) begin : g_bad
         $error("ics_step_gen: PHASE_W must exceed SPEED_W");
      end
   endgenerate

   assign sum = {1'b0, phase} + {{(PHASE_W + 1 - SPEED_W){1'b0}}, speed};

   // The phase is cleared while stopped so every move started from a stop begins from the same point.
   always_ff @(posedge clock) begin
      if (srst) begin
         phase <= '0;
         step <= 1'b0;
      end else if (ce) begin
         phase <= run ? sum[PHASE_W-1:0] : '0;
         step <= run & sum[PHASE_W];
      end
   end
endmodule // ics_step_gen
`default_nettype wire

/* File: design/ics_axis.sv */
// Axis controller: chained interpolation moves and speed-pattern start and stop.
//
// How it works
// - Next move data is accepted into a pre-register while a move runs.
// - Underrun stop raises an interrupt request when the enable bit is set.
// - A chained run whose next move arrives late stops with an error.
// - Holding start outputs no pulses until a separate trigger arrives.
// - Broadcast 2001h releases the held move on all axes together.
// - Chained start command with next data sets the pre-register full flag.
// - Taking over the pending move clears the full flag.
// - Command 0050h starts a low-speed constant run in either mode.
// - Low-speed continuous run stops on 0049h or 004Ah.
// - Command 0051h starts a high-speed constant run without ramp.
// - Command 0049h halts pulses at once in high-speed or ramped runs.
// - Command 004Ah in a high-speed run ramps down to low speed then stops.
// - Positioning run ends when remaining count reaches zero or on 0049h.
// - Command 0052h starts ramp pattern one: accelerate, later decelerate.
// - Command 0053h starts ramp pattern two in both modes.
// - Circular step count times deceleration and serves as remaining counter.
`timescale 1ns/1ps
`default_nettype none
`include "ics_regs.svh"
module ics_axis import ics_pkg::*; #(
   parameter int FEED_W = 28,
   parameter int SPEED_W = 17,
   parameter int PHASE_W = 24
) (
   // Clock, reset and enable
   input wire logic clock,
   input wire logic srst,
   input wire logic ce,
   // Commands and broadcasts from the controller
   input wire logic cmd_valid,
   input wire logic [15:0] cmd_code,
   input wire logic bcast_valid,
   input wire logic [15:0] bcast_code,
   // Pre-register write
   input wire logic pre_wr,
   input wire logic [FEED_W-1:0] pending_feed_amount,
   input wire logic [FEED_W-1:0] circular_step_count,
   input wire logic [31:0] pending_mode_reg,
   // Speed settings
   input wire logic [SPEED_W-1:0] initial_speed,
   input wire logic [SPEED_W-1:0] target_speed,
   input wire logic [15:0] accel_rate,
   // Interrupt control
   input wire logic underrun_irq_enable,
   input wire logic irq_ack,
   // Motor outputs
   output logic pulse_out,
   output logic dir_out,
   // Status
   output logic busy,
   output logic pending_full_flag,
   output logic error_stop,
   output logic irq_request,
   output logic [FEED_W-1:0] remaining_pulse_count,
   output logic [SPEED_W-1:0] speed_now,
   output logic [31:0] operation_mode_reg,
   output logic [15:0] main_status_word
);
   // The ramp tick counter spans the rate word and the fixed unit of clocks.
   localparam int RT_W = 16 + $clog2(`ICS_RAMP_UNIT);

   ics_state_t state, next_state;
   ics_kind_t kind, pend_kind, load_kind;
   logic [FEED_W-1:0] pre_feed, pre_circ, load_remain, feed_mag;
   logic [31:0] pre_mode;
   logic chain;
   logic [RT_W-1:0] rtick;
   logic [SPEED_W-1:0] next_speed, load_speed;
   logic step;

   // The deceleration compare widens the speed distance into the count,
   // so the count may not be narrower than the speed word.
   generate
      if (FEED_W < SPEED_W || SPEED_W < 2) begin : g_bad
         $error("ics_axis: FEED_W must be at least SPEED_W, and SPEED_W at least 2");
      end
   endgenerate

   // Command decode. Starts and chained starts carry the pattern in the
   // low two bits, so a whole group of four is matched at once.
   wire is_start = cmd_valid && (cmd_code[15:2] == 14'(`ICS_CMD_START_LOW >> 2));
   wire is_next = cmd_valid && (cmd_code[15:2] == 14'(`ICS_CMD_NEXT_LOW >> 2));
   wire cmd_stop = cmd_valid && (cmd_code == `ICS_CMD_STOP);
   wire decel_stop_cmd = cmd_valid && (cmd_code == `ICS_CMD_DECEL_STOP);
   // Only the release broadcast is decoded; other broadcasts pass by.
   wire go_bcast = bcast_valid && (bcast_code == `ICS_BCAST_START);

   // Active mode fields.
   wire md_pos = operation_mode_reg[`ICS_MD_POS];
   wire md_circ = operation_mode_reg[`ICS_MD_CIRC];
   wire md_dummy = operation_mode_reg[`ICS_MD_DUMMY];
   wire is_idle = (state == ICS_IDLE);
   wire moving = (state == ICS_RUN) || (state == ICS_DECEL);
   wire ramped = (kind == ICS_RAMP1) || (kind == ICS_RAMP2);

   // Ramp timing: one speed unit per (rate + 1) * unit clocks.
   wire [RT_W-1:0] rtick_end = {accel_rate, {($clog2(`ICS_RAMP_UNIT)){1'b1}}};
   wire ramp_tick = (rtick == rtick_end);

   // Deceleration point: the remaining count covers the steps still needed
   // to ramp back to the initial speed. With circular moves the remaining
   // count is the circular step count, so it times the ramp down as well.
   wire [SPEED_W-1:0] ramp_dist = (speed_now > initial_speed) ?
      SPEED_W'(speed_now - initial_speed) : '0;
   wire decel_pt = ramped && md_pos &&
      (remaining_pulse_count <= FEED_W'(ramp_dist));
   wire slowing = (state == ICS_DECEL) || decel_pt;
   wire at_floor = (speed_now <= initial_speed);

   // Move end and chaining decisions.
   // A stop in the same cycle as the end wins, so no hand-over follows it.
   wire pos_done = moving && md_pos && (remaining_pulse_count == '0);
   wire decel_done = (state == ICS_DECEL) && at_floor;
   wire move_end = (pos_done || decel_done) && !cmd_stop;
   wire do_start = (is_start || is_next) && is_idle;
   wire do_xfer = move_end && pending_full_flag;
   wire underrun = move_end && !pending_full_flag && chain;
   wire load = do_start || do_xfer;

   // Load values from the pre-register. The sign of the feed gives the
   // direction, and the count runs on its magnitude.
   assign load_kind = do_xfer ? pend_kind : ics_kind_t'(cmd_code[1:0]);
   assign feed_mag = pre_feed[FEED_W-1] ? FEED_W'(-pre_feed) : pre_feed;
   assign load_remain = pre_mode[`ICS_MD_CIRC] ? pre_circ : feed_mag;
   assign load_speed = (load_kind == ICS_HIGH) ? target_speed : initial_speed;

   // Step visibility: dummy moves keep timing but put out no pulses.
   // Counted and visible steps differ for dummy moves and for continuous runs, which count nothing.
   wire vis_step = step && moving && !md_dummy && !(md_pos && remaining_pulse_count == '0);
   wire cnt_step = step && moving && md_pos && (remaining_pulse_count != '0);

   // An immediate stop outranks everything, and a hand-over outranks a plain end.
   always_comb begin
      next_state = state;
      case (state)
         ICS_IDLE: begin
            if (do_start) begin
               next_state = pre_mode[`ICS_MD_HOLD] ? ICS_HOLD : ICS_RUN;
            end
         end
         ICS_HOLD: begin
            // A held axis leaves only on the release broadcast or an immediate stop.
            if (cmd_stop) begin
               next_state = ICS_IDLE;
            end else if (go_bcast) begin
               next_state = ICS_RUN;
            end
         end
         ICS_RUN: begin
            if (cmd_stop) begin
               next_state = ICS_IDLE;
            end else if (do_xfer) begin
               next_state = ICS_RUN;
            end else if (move_end) begin
               next_state = ICS_IDLE;
            end else if (decel_stop_cmd) begin
               next_state = (kind == ICS_LOW) ? ICS_IDLE : ICS_DECEL;
            end
         end
         ICS_DECEL: begin
            if (cmd_stop) begin
               next_state = ICS_IDLE;
            end else if (do_xfer) begin
               next_state = ICS_RUN;
            end else if (move_end) begin
               next_state = ICS_IDLE;
            end
         end
         default: next_state = ICS_IDLE;
      endcase
   end

   // Speed moves one unit per ramp tick. Idle forces zero, so a later start
   // never inherits a stale speed.
   always_comb begin
      next_speed = speed_now;
      if (load) begin
         next_speed = load_speed;
      end else if (next_state == ICS_IDLE) begin
         next_speed = '0;
      end else if (moving && ramp_tick) begin
         if (slowing && !at_floor) begin
            next_speed = SPEED_W'(speed_now - 1'b1);
         end else if (!slowing && ramped && speed_now < target_speed) begin
            next_speed = SPEED_W'(speed_now + 1'b1);
         end
      end
   end

   // Pre-register store and full flag.
   // A write while full replaces the pending data, so the controller must
   // wait for the flag to clear before it sends the move after next.
   always_ff @(posedge clock) begin
      if (srst) begin
         pre_feed <= '0;
         pre_circ <= '0;
         pre_mode <= '0;
         pend_kind <= ICS_LOW;
         pending_full_flag <= 1'b0;
      end else if (ce) begin
         if (pre_wr) begin
            pre_feed <= pending_feed_amount;
            pre_circ <= circular_step_count;
            pre_mode <= pending_mode_reg;
         end
         if (is_next && !is_idle) begin
            pend_kind <= ics_kind_t'(cmd_code[1:0]);
            pending_full_flag <= 1'b1;
         end else if (do_xfer || cmd_stop) begin
            pending_full_flag <= 1'b0;
         end
      end
   end

   // Active move registers. The chain mark follows a move that a chained
   // start launched, and a hand-over keeps it.
   always_ff @(posedge clock) begin
      if (srst) begin
         state <= ICS_IDLE;
         kind <= ICS_LOW;
         operation_mode_reg <= '0;
         remaining_pulse_count <= '0;
         dir_out <= 1'b0;
         speed_now <= '0;
         chain <= 1'b0;
      end else if (ce) begin
         state <= next_state;
         speed_now <= next_speed;
         if (load) begin
            kind <= load_kind;
            operation_mode_reg <= pre_mode;
            remaining_pulse_count <= load_remain;
            dir_out <= pre_feed[FEED_W-1];
            chain <= do_xfer ? chain : is_next;
         end else begin
            if (cnt_step) begin
               remaining_pulse_count <= FEED_W'(remaining_pulse_count - 1'b1);
            end
            if (next_state == ICS_IDLE) begin
               chain <= 1'b0;
            end
         end
      end
   end

   // Ramp tick counter, restarted with each move.
   // Like every register here it holds while ce is low, as does the step generator.
   always_ff @(posedge clock) begin
      if (srst) begin
         rtick <= '0;
      end else if (ce) begin
         rtick <= (load || !moving || ramp_tick) ? '0 : RT_W'(rtick + 1'b1);
      end
   end

   // Error, interrupt request and outputs.
   // The error stays until the next start from idle, so it can be read later.
   // The status word is built from registered state and trails it by one cycle.
   always_ff @(posedge clock) begin
      if (srst) begin
         error_stop <= 1'b0;
         irq_request <= 1'b0;
         pulse_out <= 1'b0;
         busy <= 1'b0;
         main_status_word <= '0;
      end else if (ce) begin
         if (underrun) begin
            error_stop <= 1'b1;
         end else if (do_start) begin
            error_stop <= 1'b0;
         end
         // A new underrun in the acknowledge cycle keeps the request set.
         if (underrun && underrun_irq_enable) begin
            irq_request <= 1'b1;
         end else if (irq_ack) begin
            irq_request <= 1'b0;
         end
         pulse_out <= vis_step;
         busy <= (next_state != ICS_IDLE);
         main_status_word <= {8'h00, md_circ, chain, kind, error_stop,
            pending_full_flag, state};
      end
   end

   // Pulses only while running; held and stopped axes put out nothing.
   ics_step_gen #(
      .SPEED_W(SPEED_W),
      .PHASE_W(PHASE_W)
   ) u_step (
      .clock(clock),
      .srst(srst),
      .ce(ce),
      .run(moving && (next_state != ICS_IDLE)),
      .speed(speed_now),
      .step(step)
   );
endmodule // ics_axis
`default_nettype wire

/* File: test/ics_axis_assertions.sv */
// Concurrent checks on the axis block ports.
`timescale 1ns/1ps
`default_nettype none
module ics_axis_chk #(
   parameter int SPEED_W = 17
) (
   // Clock and reset
   input wire logic clock,
   input wire logic srst,
   input wire logic ce,
   // Controller side
   input wire logic cmd_valid,
   input wire logic [15:0] cmd_code,
   input wire logic bcast_valid,
   input wire logic [15:0] bcast_code,
   input wire logic [SPEED_W-1:0] initial_speed,
   input wire logic [SPEED_W-1:0] target_speed,
   input wire logic underrun_irq_enable,
   // Outputs
   input wire logic pulse_out,
   input wire logic busy,
   input wire logic pending_full_flag,
   input wire logic error_stop,
   input wire logic irq_request,
   input wire logic [SPEED_W-1:0] speed_now,
   input wire logic [15:0] main_status_word
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   wire logic go = ce && cmd_valid;
   wire logic held = main_status_word[1:0] == 2'b01;
   property p_start_low;
      go && cmd_code == 16'h0050 && !busy |=> busy ##1 (speed_now == initial_speed || held);
   endproperty
   a_start_low: assert property (p_start_low) else $error("low start wrong");
   property p_start_high;
      go && cmd_code == 16'h0051 && !busy |=> busy ##1 (speed_now == target_speed || held);
   endproperty
   a_start_high: assert property (p_start_high) else $error("high start wrong");
   property p_stop;
      go && cmd_code == 16'h0049 && busy |-> ##[1:2] !busy;
   endproperty
   a_stop: assert property (p_stop) else $error("stop ignored");
   property p_hold_quiet;
      held |-> !pulse_out;
   endproperty
   a_hold_quiet: assert property (p_hold_quiet) else $error("pulse while held");
   property p_bcast;
      held && ce && bcast_valid && bcast_code == 16'h2001 |-> ##[1:2] main_status_word[1:0] == 2'b11;
   endproperty
   a_bcast: assert property (p_bcast) else $error("held move not released");
   property p_full_set;
      go && busy && cmd_code[15:2] == 14'h0016 |-> ##[1:2] pending_full_flag;
   endproperty
   a_full_set: assert property (p_full_set) else $error("full not set");
   property p_full_clear;
      $fell(pending_full_flag) && !$past(cmd_valid) |-> busy;
   endproperty
   a_full_clear: assert property (p_full_clear) else $error("gap at handover");
   property p_err;
      $rose(error_stop) |-> ##[0:1] (!busy && (irq_request || !underrun_irq_enable));
   endproperty
   a_err: assert property (p_err) else $error("underrun stop wrong");
endmodule // ics_axis_chk
bind ics_axis ics_axis_chk #(.SPEED_W(SPEED_W)) chk_u (.clock(clock), .srst(srst), .ce(ce),
   .cmd_valid(cmd_valid), .cmd_code(cmd_code), .bcast_valid(bcast_valid),
   .bcast_code(bcast_code), .initial_speed(initial_speed), .target_speed(target_speed),
   .underrun_irq_enable(underrun_irq_enable), .pulse_out(pulse_out), .busy(busy),
   .pending_full_flag(pending_full_flag), .error_stop(error_stop),
   .irq_request(irq_request), .speed_now(speed_now), .main_status_word(main_status_word));
`default_nettype wire

/* File: test/ics_center.sv */
// Center controller model: commands, broadcasts and pre-register writes.
`timescale 1ns/1ps
`default_nettype none
module ics_center (
   // Clock
   input wire logic clock,
   // Toward the axis
   output logic cmd_valid,
   output logic [15:0] cmd_code,
   output logic bcast_valid,
   output logic [15:0] bcast_code,
   output logic pre_wr,
   output logic [27:0] feed,
   output logic [31:0] mode
);
   initial begin
      {cmd_valid, bcast_valid, pre_wr} = 3'h0;
      {cmd_code, bcast_code, feed, mode} = '0;
   end
   // Released lines show the inverse, so a stale value cannot pass.
   task automatic cmd(input logic [15:0] c);
      @(negedge clock);
      cmd_valid = 1'b1;
      cmd_code = c;
      @(negedge clock);
      cmd_valid = 1'b0;
      cmd_code = ~c;
   endtask
   // One broadcast reaches every held axis at once.
   task automatic bc(input logic [15:0] c);
      @(negedge clock);
      bcast_valid = 1'b1;
      bcast_code = c;
      @(negedge clock);
      bcast_valid = 1'b0;
      bcast_code = ~c;
   endtask
   // The caller sets the dummy bit on axes that sit out a circle.
   task automatic pre(input logic [27:0] f, input logic [31:0] m);
      @(negedge clock);
      pre_wr = 1'b1;
      feed = f;
      mode = m;
      @(negedge clock);
      pre_wr = 1'b0;
      feed = ~f;
      mode = ~m;
   endtask
endmodule // ics_center
`default_nettype wire

/* File: test/test_interp_chain_speed_cmds.sv */
// Self-checking bench for the axis block.
`timescale 1ns/1ps
`default_nettype none
module test_interp_chain_speed_cmds;
   logic clock, srst, ce, irq_ack, en, cmd_valid, bcast_valid, pre_wr;
   logic pulse_out, dir_out, busy, full, err, irq;
   logic [15:0] cmd_code, bcast_code, msw, rate;
   logic [27:0] feed, rem, circ;
   logic [31:0] mode, omode;
   logic [16:0] fl, fh, spd;
   logic [31:0] seed = 32'h96a6;
   int n_fail = 0, comparisons = 0, npulse = 0, p0, n, k, s;
   ics_center ctl (.clock(clock), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .bcast_valid(bcast_valid), .bcast_code(bcast_code), .pre_wr(pre_wr),
      .feed(feed), .mode(mode));
   ics_axis dut_u (.clock(clock), .srst(srst), .ce(ce), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .bcast_valid(bcast_valid), .bcast_code(bcast_code),
      .pre_wr(pre_wr), .pending_feed_amount(feed), .circular_step_count(circ),
      .pending_mode_reg(mode), .initial_speed(fl), .target_speed(fh),
      .accel_rate(rate), .underrun_irq_enable(en), .irq_ack(irq_ack),
      .pulse_out(pulse_out), .dir_out(dir_out), .busy(busy), .pending_full_flag(full),
      .error_stop(err), .irq_request(irq), .remaining_pulse_count(rem),
      .speed_now(spd), .operation_mode_reg(omode), .main_status_word(msw));
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   always @(posedge clock) if (pulse_out === 1'b1) npulse++;
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s exp %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wait_idle();
      for (int i = 0; i < 6000 && busy !== 1'b0; i++) @(negedge clock);
      check("idle", busy, 0);
   endtask
   task automatic stop_test();
      $display("fails %0d comparisons %0d", n_fail, comparisons);
      if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      {srst, ce, irq_ack, en} = 4'b1101;
      rate = 16'h0000;
      circ = 28'h0;
      fh = {10'h3ff, 7'(xs())};
      repeat (6) @(negedge clock);
      srst = 1'b0;
      // Pass 1 runs a negative feed, pass 2 counts from the circular step count.
      for (k = 0; k < 3; k++) begin
         void'(xs());
         n = seed[1:0] + 1;
         fl = {9'h1ff, seed[9:2]};
         circ = n[27:0];
         ctl.pre(k == 1 ? 28'(-n) : (k == 2 ? 28'h7 : n[27:0]), (k == 2) ? 32'h11 : 32'h1);
         p0 = npulse;
         ctl.cmd(16'h0050);
         check("busy", busy, 1);
         check("speed", spd, fl);
         check("remain", rem, n);
         check("dir", dir_out, k == 1);
         check("mode", omode, (k == 2) ? 32'h11 : 32'h1);
         wait_idle();
         check("pulses", npulse - p0, n);
      end
      // A dummy move runs its time out but must stay silent.
      p0 = npulse;
      ctl.pre(28'h3, 32'h40000001);
      ctl.cmd(16'h0050);
      wait_idle();
      check("dummy", npulse - p0, 0);
      fl = 17'h1ff00;
      for (s = 0; s < 2; s++)
         for (k = 0; k < 4; k++) begin
            void'(xs());
            rate = {15'h0, seed[0]};
            ctl.pre(28'h0, 32'h0);
            ctl.cmd(16'h0050 + k[15:0]);
            repeat (200) @(negedge clock);
            if (k == 0) check("low", spd, fl);
            if (k == 1) check("high", spd, fh);
            if (k > 1) check("ramp", spd > fl && spd < fh, 1);
            // A low enable must freeze the ramp where it stands.
            if (k == 3 && s == 0) begin
               ce = 1'b0;
               p0 = spd;
               repeat (40) @(negedge clock);
               check("freeze", spd, p0);
               ce = 1'b1;
            end
            ctl.cmd(s ? 16'h004a : 16'h0049);
            if (s == 0 || k == 0) check("halt", busy, 0);
            else begin
               @(negedge clock);
               check("decel", busy, 1);
               @(negedge clock);
               check("state", msw[1:0], 2'b10);
               wait_idle();
               check("end", spd, 0);
            end
         end
      ctl.pre(28'h2, 32'h4001);
      p0 = npulse;
      ctl.cmd(16'h0050);
      repeat (300) @(negedge clock);
      check("hold", msw[1:0], 2'b01);
      check("quiet", npulse - p0, 0);
      ctl.bc(16'h2001);
      wait_idle();
      check("held run", npulse - p0, 2);
      ctl.pre(28'h2, 32'h1);
      p0 = npulse;
      ctl.cmd(16'h0058);
      ctl.pre(28'h1, 32'h1);
      ctl.cmd(16'h0058);
      @(negedge clock);
      check("full", full, 1);
      for (k = 0; k < 2000 && full !== 1'b0; k++) @(negedge clock);
      check("taken", {full, busy}, 2'b01);
      wait_idle();
      check("chain pulses", npulse - p0, 3);
      check("error", err, 1);
      check("irq", irq, 1);
      irq_ack = 1'b1;
      @(negedge clock);
      irq_ack = 1'b0;
      check("ack", irq, 0);
      stop_test();
   end
   // The run needs about 6000 cycles; this leaves ample margin.
   initial begin
      repeat (60000) @(posedge clock);
      n_fail++;
      stop_test();
   end
endmodule // test_interp_chain_speed_cmds
`default_nettype wire
